// *** logic/nuw_pkg.sv ***
/*
  Shared constants and types of the nonvolatile memory write/erase control.
  Assumes a 10 MHz core clock; offsets are byte addresses on AXI4-Lite.
*/
package nuw_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int EE_WRITE_NS = 4000;
  localparam int ROW_ERASE_NS = 2000;
  localparam int ROW_PROG_NS = 2000;
  localparam int EE_WRITE_CYC =
    (EE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_ERASE_CYC =
    (ROW_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_PROG_CYC =
    (ROW_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 14;
  localparam int ROW_WORDS = 32;
  localparam int ROW_LSB = $clog2(ROW_WORDS);

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_WPROT = 8'h14;
  localparam int NUM_REGS = 6;

  localparam int B_START = 0;
  localparam int B_WRITE_ENABLE_GATE = 2;
  localparam int B_WRERR = 3;
  localparam int B_ERASE = 4;
  localparam int B_LATCH = 5;
  localparam int B_REGION = 6;
  localparam int B_DONE = 0;
  localparam int B_IRQEN = 1;
  localparam int B_BUSY = 2;
  localparam int B_RGN_LSB = 4;

  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  localparam logic [14:0] UID_LAST = 15'h0003;
  localparam logic [14:0] RSVD_ADDR = 15'h0004;
  localparam logic [14:0] ID_LAST = 15'h0006;
  localparam logic [14:0] CFG_LAST = 15'h000B;
  localparam logic [14:0] INFO_FIRST = 15'h0100;
  localparam logic [14:0] INFO_LAST = 15'h02FF;
  localparam logic [14:0] EE_FIRST = 15'h7000;
  localparam logic [14:0] EE_LAST = 15'h70FF;

  localparam logic [14:0] ADDR_RST = 15'h0000;
  localparam logic [13:0] DATA_RST = 14'h0000;
  localparam logic [14:0] WPROT_RST = 15'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    RG_PFM = 3'h0,
    RG_UID = 3'h1,
    RG_RSVD = 3'h2,
    RG_ID = 3'h3,
    RG_CFG = 3'h4,
    RG_INFO = 3'h5,
    RG_EE = 3'h6,
    RG_NONE = 3'h7
  } nuw_region_type;

endpackage : nuw_pkg

// *** logic/nuw_ctl_if.sv ***
/*
  Signals between the register front end, the unlock detector and the
  region decoder. Assumes all three sit on the same core clock.
*/
`timescale 1ns/10ps
interface nuw_ctl_if;
  logic key_wr;
  logic [7:0] key_val;
  logic ctrl_wr;
  logic start_bit;
  logic write_enable_gate_bit;
  logic other_wr;
  logic unlock;
  logic [14:0] addr;
  logic region_sel;
  nuw_pkg::nuw_region_type region;
  logic writable;

  modport top_mp(output key_wr, key_val, ctrl_wr, start_bit, write_enable_gate_bit,
                 output other_wr, addr, region_sel,
                 input unlock, region, writable);
  modport unl_mp(input key_wr, key_val, ctrl_wr, start_bit, write_enable_gate_bit,
                 input other_wr, output unlock);
  modport dec_mp(input addr, region_sel, output region, writable);
endinterface : nuw_ctl_if

// *** logic/nuw_unlock.sv ***
/*
  Key sequence detector: two key writes then a start write, back to back
  in register-write order. Assumes one register write event per cycle.
*/
`timescale 1ns/10ps
module nuw_unlock (
  input wire logic clk_i,
  input wire logic rst_n_i,
  nuw_ctl_if.unl_mp unl
);

  typedef enum logic [2:0] {
    UL_IDLE = 3'b001,
    UL_KEY1 = 3'b010,
    UL_KEY2 = 3'b100
  } nuw_ul_state_type;

  nuw_ul_state_type st_q;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= UL_IDLE;
    end else if (unl.key_wr) begin
      if (unl.key_val == nuw_pkg::KEY_FIRST) begin
        st_q <= UL_KEY1;
      end else if (st_q == UL_KEY1 &&
                   unl.key_val == nuw_pkg::KEY_SECOND) begin
        st_q <= UL_KEY2;
      end else begin
        st_q <= UL_IDLE;
      end
    end else if (unl.ctrl_wr || unl.other_wr) begin
      st_q <= UL_IDLE;
    end
  end

  // Start without write enable never unlocks
  assign unl.unlock = unl.ctrl_wr && unl.start_bit && unl.write_enable_gate_bit &&
                      st_q == UL_KEY2;

  ////////////////////////////////////////////////////////////////////////
  AST_STRAY_WRITE_RESETS: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    unl.other_wr |=> st_q == UL_IDLE)
    else $error("stray write did not reset unlock");
  AST_NO_WRITE_ENABLE_GATE_NO_UNLOCK: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    unl.ctrl_wr && !unl.write_enable_gate_bit |-> !unl.unlock)
    else $error("unlock without write enable");
  AST_FIRST_KEY: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    unl.key_wr && unl.key_val == nuw_pkg::KEY_FIRST |=> st_q == UL_KEY1)
    else $error("first key not tracked");

endmodule : nuw_unlock

// *** logic/nuw_region_dec.sv ***
/*
  Region decoder for the target address and region select bit.
  Purely combinational; the caller registers anything it keeps.
*/
`timescale 1ns/10ps
module nuw_region_dec (
  nuw_ctl_if.dec_mp dec
);

  always_comb begin
    dec.region = nuw_pkg::RG_NONE;
    if (!dec.region_sel) begin
      // Whole 15-bit span is program flash
      dec.region = nuw_pkg::RG_PFM;
    end else if (dec.addr <= nuw_pkg::UID_LAST) begin
      dec.region = nuw_pkg::RG_UID;
    end else if (dec.addr == nuw_pkg::RSVD_ADDR) begin
      dec.region = nuw_pkg::RG_RSVD;
    end else if (dec.addr <= nuw_pkg::ID_LAST) begin
      dec.region = nuw_pkg::RG_ID;
    end else if (dec.addr <= nuw_pkg::CFG_LAST) begin
      dec.region = nuw_pkg::RG_CFG;
    end else if (dec.addr >= nuw_pkg::INFO_FIRST &&
                 dec.addr <= nuw_pkg::INFO_LAST) begin
      dec.region = nuw_pkg::RG_INFO;
    end else if (dec.addr >= nuw_pkg::EE_FIRST &&
                 dec.addr <= nuw_pkg::EE_LAST) begin
      dec.region = nuw_pkg::RG_EE;
    end
  end

  // Configuration words are writable by the array but not by self-write
  assign dec.writable = dec.region inside {nuw_pkg::RG_PFM,
    nuw_pkg::RG_UID, nuw_pkg::RG_EE};

endmodule : nuw_region_dec

// *** logic/nuw_top.sv ***
/*
  Self-write control for program flash and data EEPROM: AXI4-Lite register
  slave, unlock detection, operation dispatch, CPU stall and done flag.
  Assumes the arrays accept one-cycle command pulses with address and data.
*/
`timescale 1ns/10ps

module nuw_top #(
  parameter int EE_CYC = nuw_pkg::EE_WRITE_CYC,
  parameter int ERASE_CYC = nuw_pkg::ROW_ERASE_CYC,
  parameter int PROG_CYC = nuw_pkg::ROW_PROG_CYC,
  parameter int TMR_W = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic pf_erase_o,
  output logic pf_prog_o,
  output logic latch_load_o,
  output logic ee_write_o,
  output logic [14:0] nvm_addr_o,
  output logic [13:0] nvm_data_word_o,
  output logic region_select_bit_o,
  output logic cpu_stall_o,
  output logic nvm_done_irq_o
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EE = 3'b010,
    ST_PF = 3'b100
  } nuw_state_type;

  logic rst_meta_q, rst_n_q;
  logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, wmask, wval;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_go, w_hit, r_hit, sel_ctrl, sel_key, sel_stat;
  logic [2:0] widx, ridx;
  logic [31:0] view [8];
  logic write_enable_gate_q, erase_q, latch_q, regs_q, wrerr_q;
  logic done_q, irq_en_q;
  logic [14:0] addr_q, wp_limit_q;
  logic [13:0] data_q;
  nuw_state_type st_q;
  logic [TMR_W-1:0] tmr_q;
  logic busy, fin, blocked, unl_go;
  logic go_ee, go_erase, go_load, go_prog;
  logic pf_erase_q, pf_prog_q, latch_load_q, ee_write_q, rgn_q;
  logic [14:0] nvm_addr_q;
  logic [13:0] nvm_data_q;
  nuw_ctl_if ctl ();

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write address and data taken in either order, one write at a time
  assign s_axi_awready_o = !aw_got_q && !bvalid_q;
  assign s_axi_wready_o = !w_got_q && !bvalid_q;
  assign wr_go = aw_got_q && w_got_q && !bvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end else if (wr_go) begin
        aw_got_q <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end else if (wr_go) begin
        w_got_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bvalid_q <= 1'b0;
      bresp_q <= nuw_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= w_hit ? nuw_pkg::RESP_OKAY : nuw_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign ridx = s_axi_araddr_i[4:2];
  assign r_hit = s_axi_araddr_i[7:5] == 3'h0 &&
                 s_axi_araddr_i[1:0] == 2'h0 &&
                 32'(ridx) < nuw_pkg::NUM_REGS;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= nuw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_q <= 1'b1;
      rdata_q <= r_hit ? view[ridx] : 32'h0000_0000;
      rresp_q <= r_hit ? nuw_pkg::RESP_OKAY : nuw_pkg::RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register views; unused slots read as zero so any index is safe
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      view[i] = 32'h0000_0000;
    end
    view[nuw_pkg::OFS_CTRL[4:2]][nuw_pkg::B_START] = busy;
    view[nuw_pkg::OFS_CTRL[4:2]][nuw_pkg::B_WRITE_ENABLE_GATE] = write_enable_gate_q;
    view[nuw_pkg::OFS_CTRL[4:2]][nuw_pkg::B_WRERR] = wrerr_q;
    view[nuw_pkg::OFS_CTRL[4:2]][nuw_pkg::B_ERASE] = erase_q;
    view[nuw_pkg::OFS_CTRL[4:2]][nuw_pkg::B_LATCH] = latch_q;
    view[nuw_pkg::OFS_CTRL[4:2]][nuw_pkg::B_REGION] = regs_q;
    view[nuw_pkg::OFS_ADDR[4:2]][14:0] = addr_q;
    view[nuw_pkg::OFS_DATA[4:2]][13:0] = data_q;
    view[nuw_pkg::OFS_STAT[4:2]][nuw_pkg::B_DONE] = done_q;
    view[nuw_pkg::OFS_STAT[4:2]][nuw_pkg::B_IRQEN] = irq_en_q;
    view[nuw_pkg::OFS_STAT[4:2]][nuw_pkg::B_BUSY] = busy;
    view[nuw_pkg::OFS_STAT[4:2]][nuw_pkg::B_RGN_LSB +: 3] = ctl.region;
    view[nuw_pkg::OFS_WPROT[4:2]][14:0] = wp_limit_q;
  end

  assign widx = awaddr_q[4:2];
  assign w_hit = awaddr_q[7:5] == 3'h0 && awaddr_q[1:0] == 2'h0 &&
                 32'(widx) < nuw_pkg::NUM_REGS;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                  {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wval = (view[widx] & ~wmask) | (wdata_q & wmask);
  assign sel_ctrl = wr_go && awaddr_q == nuw_pkg::OFS_CTRL;
  assign sel_key = wr_go && awaddr_q == nuw_pkg::OFS_KEY;
  assign sel_stat = wr_go && awaddr_q == nuw_pkg::OFS_STAT;

  ////////////////////////////////////////////////////////////////////////
  assign ctl.key_wr = sel_key;
  assign ctl.key_val = wval[7:0];
  assign ctl.ctrl_wr = sel_ctrl;
  assign ctl.start_bit = wval[nuw_pkg::B_START];
  assign ctl.write_enable_gate_bit = wval[nuw_pkg::B_WRITE_ENABLE_GATE];
  assign ctl.other_wr = wr_go && !sel_key && !sel_ctrl;
  assign ctl.addr = addr_q;
  // Taken from the raw write, not wval, to keep view out of its own fan-in
  assign ctl.region_sel = (sel_ctrl && wstrb_q[0]) ?
                          wdata_q[nuw_pkg::B_REGION] : regs_q;

  nuw_unlock u_unlock (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .unl(ctl.unl_mp)
  );

  nuw_region_dec u_dec (
    .dec(ctl.dec_mp)
  );

  // Low program rows below the limit are locked against self-write
  assign blocked = !ctl.writable || (!ctl.region_sel &&
                   addr_q < wp_limit_q);
  assign unl_go = ctl.unlock && !busy;
  assign go_ee = unl_go && !blocked && ctl.region == nuw_pkg::RG_EE;
  assign go_erase = unl_go && !blocked && ctl.region != nuw_pkg::RG_EE &&
                    wval[nuw_pkg::B_ERASE];
  assign go_load = unl_go && !blocked && ctl.region != nuw_pkg::RG_EE &&
                   !wval[nuw_pkg::B_ERASE] && wval[nuw_pkg::B_LATCH];
  assign go_prog = unl_go && !blocked && ctl.region != nuw_pkg::RG_EE &&
                   !wval[nuw_pkg::B_ERASE] && !wval[nuw_pkg::B_LATCH];

  ////////////////////////////////////////////////////////////////////////
  // Control fields; the start bit is the busy state and cannot be cleared
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      write_enable_gate_q <= 1'b0;
      erase_q <= 1'b0;
      latch_q <= 1'b0;
      regs_q <= 1'b0;
    end else if (sel_ctrl) begin
      write_enable_gate_q <= wval[nuw_pkg::B_WRITE_ENABLE_GATE];
      erase_q <= wval[nuw_pkg::B_ERASE];
      latch_q <= wval[nuw_pkg::B_LATCH];
      regs_q <= wval[nuw_pkg::B_REGION];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wrerr_q <= 1'b0;
    end else if (unl_go && blocked) begin
      wrerr_q <= 1'b1;
    end else if (sel_ctrl && !wval[nuw_pkg::B_WRERR]) begin
      wrerr_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      addr_q <= nuw_pkg::ADDR_RST;
      data_q <= nuw_pkg::DATA_RST;
      wp_limit_q <= nuw_pkg::WPROT_RST;
      irq_en_q <= 1'b0;
    end else begin
      if (wr_go && awaddr_q == nuw_pkg::OFS_ADDR) begin
        addr_q <= wval[14:0];
      end
      if (wr_go && awaddr_q == nuw_pkg::OFS_DATA) begin
        data_q <= wval[13:0];
      end
      if (wr_go && awaddr_q == nuw_pkg::OFS_WPROT) begin
        wp_limit_q <= wval[14:0];
      end
      if (sel_stat) begin
        irq_en_q <= wval[nuw_pkg::B_IRQEN];
      end
    end
  end

  // Completion beats a same-cycle write-one-to-clear
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      done_q <= 1'b0;
    end else if (fin) begin
      done_q <= 1'b1;
    end else if (sel_stat && wdata_q[nuw_pkg::B_DONE] && wstrb_q[0]) begin
      done_q <= 1'b0;
    end
  end

  assign nvm_done_irq_o = done_q && irq_en_q;

  ////////////////////////////////////////////////////////////////////////
  assign busy = st_q != ST_IDLE;
  assign fin = busy && tmr_q == '0;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= ST_IDLE;
      tmr_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (go_ee) begin
            st_q <= ST_EE;
            tmr_q <= TMR_W'(EE_CYC - 1);
          end else if (go_erase) begin
            st_q <= ST_PF;
            tmr_q <= TMR_W'(ERASE_CYC - 1);
          end else if (go_prog) begin
            st_q <= ST_PF;
            tmr_q <= TMR_W'(PROG_CYC - 1);
          end
        end
        ST_EE, ST_PF: begin
          if (fin) begin
            st_q <= ST_IDLE;
          end else begin
            tmr_q <= tmr_q - 1'b1;
          end
        end
      endcase
    end
  end

  assign cpu_stall_o = st_q == ST_PF;

  // Array commands; erase presents the row base only
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pf_erase_q <= 1'b0;
      pf_prog_q <= 1'b0;
      latch_load_q <= 1'b0;
      ee_write_q <= 1'b0;
      nvm_addr_q <= nuw_pkg::ADDR_RST;
      nvm_data_q <= nuw_pkg::DATA_RST;
      rgn_q <= 1'b0;
    end else begin
      pf_erase_q <= go_erase;
      pf_prog_q <= go_prog;
      latch_load_q <= go_load;
      ee_write_q <= go_ee;
      if (unl_go) begin
        nvm_addr_q <= go_erase ? {addr_q[14:nuw_pkg::ROW_LSB],
                      {nuw_pkg::ROW_LSB{1'b0}}} : addr_q;
        nvm_data_q <= data_q;
        rgn_q <= ctl.region_sel;
      end
    end
  end

  assign pf_erase_o = pf_erase_q;
  assign pf_prog_o = pf_prog_q;
  assign latch_load_o = latch_load_q;
  assign ee_write_o = ee_write_q;
  assign nvm_addr_o = nvm_addr_q;
  assign nvm_data_word_o = nvm_data_q;
  assign region_select_bit_o = rgn_q;

  ////////////////////////////////////////////////////////////////////////
  AST_OP_ONLY_AFTER_UNLOCK: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    (pf_erase_o || pf_prog_o || latch_load_o || ee_write_o) |->
      $past(ctl.unlock))
    else $error("array command without unlock");
  AST_ERASE_STALLS: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    go_erase |=> cpu_stall_o [*4])
    else $error("row erase did not stall the CPU");
  AST_EE_NO_STALL: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    st_q == ST_EE |-> !cpu_stall_o && view[0][nuw_pkg::B_START])
    else $error("EEPROM write stalled or start bit low");
  AST_EE_RUNS_ON: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    $rose(st_q == ST_EE) |-> (st_q == ST_EE) [*4])
    else $error("EEPROM write cut short");
  AST_DONE_ON_FINISH: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    fin |=> done_q && !busy)
    else $error("done flag not set on completion");
  AST_IRQ_FOLLOWS_DONE: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    fin && irq_en_q && !sel_stat |=> nvm_done_irq_o)
    else $error("done interrupt missing");
  AST_PROTECT_BLOCKS: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    unl_go && blocked |=> !busy && !pf_erase_o && !pf_prog_o && wrerr_q)
    else $error("protected target not blocked");
  AST_ROW_ALIGNED: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    pf_erase_o |-> nvm_addr_o[nuw_pkg::ROW_LSB-1:0] == '0)
    else $error("erase address not row aligned");
  AST_WRITE_ENABLE_GATE_KEPT: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    fin && !sel_ctrl |=> write_enable_gate_q == $past(write_enable_gate_q))
    else $error("write enable changed at completion");
  AST_CFG_READ_ONLY: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    ctl.region_sel && addr_q inside {[15'h0004:15'h000B]} |->
      !ctl.writable)
    else $error("reserved, ID or config region writable");

endmodule : nuw_top

// *** tb/nuw_arrays_model.sv ***
/* Array stand-in: counts command pulses and stall cycles.
   Assumes one-cycle pulses from the controller. */
`timescale 1ns/10ps
module nuw_arrays_model (
  input wire logic clk_i,
  input wire logic pf_erase_i,
  input wire logic pf_prog_i,
  input wire logic latch_load_i,
  input wire logic ee_write_i,
  input wire logic cpu_stall_i
);
  int n_er = 0, n_pg = 0, n_ll = 0, n_ee = 0, n_st = 0;
  always @(posedge clk_i) begin
    n_er += pf_erase_i;
    n_pg += pf_prog_i;
    n_ll += latch_load_i;
    n_ee += ee_write_i;
    n_st += cpu_stall_i;
  end
endmodule : nuw_arrays_model

// *** tb/nvm_unlock_write_erase_control_bench.sv ***
/* Bench: AXI4-Lite master, array stand-in, random addresses.
   Assumes short op times and the offsets of the register map. */
`timescale 1ns/10ps
module nvm_unlock_write_erase_control_bench;
  localparam int OPC = 16;
  logic clk_i = 0, nrst_i = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd, rdv, seed = 32'h0001_024e;
  logic [3:0] ws = 4'hf;
  logic awr, wrr, bv, arr, rv, st, irq, er, pg, ll, ee;
  logic [1:0] br, rr, rrv, brv;
  logic [14:0] na;
  logic [13:0] nd;
  logic rs;
  logic [31:0] dv;
  int n_fail = 0, total_checks = 0, cyc = 0, e0, e1;
  always #50 clk_i = ~clk_i;
  nuw_top #(.EE_CYC(OPC), .ERASE_CYC(OPC), .PROG_CYC(OPC)) i_nuw_top (
    .clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_bresp_o(br),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rd),
    .s_axi_rresp_o(rr), .pf_erase_o(er), .pf_prog_o(pg),
    .latch_load_o(ll), .ee_write_o(ee), .nvm_addr_o(na),
    .nvm_data_word_o(nd), .region_select_bit_o(rs), .cpu_stall_o(st),
    .nvm_done_irq_o(irq));
  nuw_arrays_model i_nuw_arrays_model (.clk_i(clk_i), .pf_erase_i(er),
    .pf_prog_i(pg), .latch_load_i(ll), .ee_write_i(ee), .cpu_stall_i(st));
////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic conclude();
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [2:0] rg(input int s, input logic [14:0] a);
    if (s == 0) return 3'h0;
    if (a <= 15'h0003) return 3'h1;
    if (a == 15'h0004) return 3'h2;
    if (a <= 15'h0006) return 3'h3;
    if (a <= 15'h000b) return 3'h4;
    if (a >= 15'h0100 && a <= 15'h02ff) return 3'h5;
    if (a >= 15'h7000 && a <= 15'h70ff) return 3'h6;
    return 3'h7;
  endfunction : rg
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw;
    @(posedge clk_i);
    ta = 0;
    tw = 0;
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    while (!(ta && tw)) begin
      @(posedge clk_i);
      if (!ta && awr === 1'b1) begin
        ta = 1;
        awv <= 0;
      end
      if (!tw && wrr === 1'b1) begin
        tw = 1;
        wv <= 0;
      end
    end
    do @(posedge clk_i); while (bv !== 1'b1);
    brv = br;
    bry <= 0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_i);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do @(posedge clk_i); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge clk_i); while (rv !== 1'b1);
    rdv = rd;
    rrv = rr;
    rry <= 0;
  endtask : rdr
  // Keys then start, nothing between
  task automatic op(input logic [31:0] c);
    wr(8'h04, 32'h55);
    wr(8'h04, 32'haa);
    wr(8'h00, c);
  endtask : op
////////////////////////////////////////
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    logic [14:0] a;
    logic [14:0] cr [8];
    cr = '{15'h0003, 15'h0004, 15'h0005, 15'h000b,
      15'h000c, 15'h00ff, 15'h02ff, 15'h70ff};
    repeat (2) @(posedge clk_i);
    nrst_i <= 1;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 16; i++) begin
      a = (i < 8) ? cr[i] : 15'(xs());
      if (i > 11) a[14:8] = 7'h70;
      for (int s = 0; s < 2; s++) begin
        wr(8'h00, (s != 0) ? 32'h40 : 32'h0);
        wr(8'h08, {17'h0, a});
        rdr(8'h10);
        chk(rdv[6:4], rg(s, a));
      end
    end
    rdr(8'h40);
    chk(rrv, nuw_pkg::RESP_SLVERR);
    wr(8'h40, 32'h0);
    chk(brv, nuw_pkg::RESP_SLVERR);
    wr(8'h10, 32'h2);
    chk(brv, nuw_pkg::RESP_OKAY);
    wr(8'h00, 32'h44);
    dv = xs() & 32'hff;
    wr(8'h0c, dv);
    e0 = i_nuw_arrays_model.n_ee;
    op(32'h45);
    rdr(8'h00);
    chk(rdv[0], 1);
    chk(st, 0);
    chk(na, {17'h0, a});
    chk(nd, dv);
    chk(rs, 1);
    wr(8'h00, 32'h44);
    rdr(8'h00);
    chk(rdv[0], 1);
    for (int k = 0; k < 40 && rdv[0]; k++) rdr(8'h00);
    chk(rdv[0], 0);
    chk(rdv[2], 1);
    chk(i_nuw_arrays_model.n_ee - e0, 1);
    rdr(8'h10);
    chk(rdv[0], 1);
    chk(irq, 1);
    wr(8'h10, 32'h3);
    chk(irq, 0);
    e0 = i_nuw_arrays_model.n_ee;
    wr(8'h04, 32'h55);
    wr(8'h08, {17'h0, a});
    wr(8'h04, 32'haa);
    wr(8'h00, 32'h45);
    op(32'h41);
    rdr(8'h00);
    chk(rdv[0], 0);
    chk(i_nuw_arrays_model.n_ee - e0, 0);
    wr(8'h14, 32'h100);
    wr(8'h00, 32'h14);
    wr(8'h08, 32'h20);
    e0 = i_nuw_arrays_model.n_er;
    op(32'h15);
    rdr(8'h00);
    chk(rdv[3], 1);
    chk(rdv[0], 0);
    chk(i_nuw_arrays_model.n_er - e0, 0);
    wr(8'h00, 32'h14);
    wr(8'h08, 32'h200 | (xs() & 32'h1f));
    e1 = i_nuw_arrays_model.n_st;
    op(32'h15);
    rdv = 0;
    for (int k = 0; k < 60 && !rdv[0]; k++) rdr(8'h10);
    chk(i_nuw_arrays_model.n_er - e0, 1);
    chk(i_nuw_arrays_model.n_st - e1, OPC);
    chk(irq, 1);
    chk(na, 32'h200);
    chk(rs, 0);
    rdr(8'h00);
    chk(rdv[2], 1);
    wr(8'h10, 32'h3);
    wr(8'h08, 32'h300);
    dv = xs() & 32'h3fff;
    wr(8'h0c, dv);
    e0 = i_nuw_arrays_model.n_ll;
    e1 = i_nuw_arrays_model.n_st;
    op(32'h25);
    op(32'h05);
    repeat (OPC + 4) @(posedge clk_i);
    chk(i_nuw_arrays_model.n_ll - e0, 1);
    chk(i_nuw_arrays_model.n_pg, 1);
    chk(i_nuw_arrays_model.n_st - e1, OPC);
    chk(na, 32'h300);
    chk(nd, dv);
    conclude();
  end
endmodule : nvm_unlock_write_erase_control_bench
